//--- hw/sdc_datagram_chain.sv
// Driver datagram generator: walks the chain memory, serialises primary
// signals in the driver's fixed bit order, drives select lines, and lets
// one cover sequence patch a datagram. Same-clock control ports only.
`timescale 1ns/1ps
//
// Contract
// - Send a stepping datagram per new microstep.
// - One chain byte picks each bit's signal.
// - Chain area starts at 0x80, first bit.
// - Chain registers are two bytes, numbered 0-31.
// - Addresses step by two; LSB is read/write.
// - Code in bits 0-4; bit 5 advances driver.
// - Select mode 1 gives one line per driver.
// - Changes reach driver only with next datagram.
// - Continuous update sends datagrams back to back.
// - Last driver index sets drivers per datagram.
// - Cover replaces one stepping datagram exactly once.
// - Cover has position, length and bit sequence.
// - Cover position zero is first driver bit 18.
// - Cover accepted only when idle and none pending.
module sdc_datagram_chain
  import sdc_pkg::*;
#(
  parameter int DRV_W       = 2,                 // Driver index width
  parameter int HALF_CYCLES = SDC_SCK_HALF_CYC   // Serial clock half period
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        cfgStrobe,
  input  wire logic [7:0]                  cfgAddr,
  input  wire logic [15:0]                 cfgWrData,
  output logic      [15:0]                 cfgRdData,
  output logic                             cfgRdValid,
  input  wire logic [(32<<DRV_W)-1:0]      primarySignals,
  input  wire logic                        stepPulse,
  input  wire logic                        continuousUpdate,
  input  wire logic                        selectLineMode,
  input  wire logic [DRV_W-1:0]            lastDriverIndex,
  input  wire logic                        coverWrite,
  input  wire logic [SDC_POS_W-1:0]        coverPosition,
  input  wire logic [SDC_LEN_W-1:0]        coverLength,
  input  wire logic [SDC_COVER_W-1:0]      coverDatagram,
  output logic                             patchPendingFlag,
  output logic                             busy,
  output logic                             sckPin,
  output logic                             sdoPin,
  output logic      [(1<<DRV_W)-1:0]       selectN
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (DRV_W < 1 || DRV_W > 3)
  begin : g_bad_drv
    $error("DRV_W must be 1 to 3");
  end

  localparam int DRIVERS = 1 << DRV_W;   // Select lines provided

  // ************************************************************
  // Chain memory and configuration port
  // ************************************************************
  logic [7:0] chainMem [SDC_CHAIN_BYTES];   // One byte per datagram bit
  wire        cfgInArea;                    // Address falls in chain area
  wire        cfgIsRead;                    // LSB flags a read
  wire  [4:0] cfgReg;                       // Register number 0..31
  wire  [5:0] cfgEven;                      // Byte index of even half
  wire  [5:0] cfgOdd;                       // Byte index of odd half

  assign cfgInArea = cfgAddr[SDC_AREA_BIT];
  assign cfgIsRead = cfgAddr[SDC_ADDR_RW_BIT];
  assign cfgReg    = cfgAddr[5:1];
  assign cfgEven   = {cfgReg, 1'b0};
  assign cfgOdd    = {cfgReg, 1'b1};

  // Memory write; no reset on the array to keep it a plain RAM
  always_ff @(posedge ref_clk)
  begin
    if (cfgStrobe && cfgInArea && !cfgIsRead)
    begin
      chainMem[cfgEven] <= cfgWrData[7:0];
      chainMem[cfgOdd]  <= cfgWrData[15:8];
    end
  end

  // Read answer one cycle after the strobe; outside the area reads zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfgRdData  <= 16'h0000;
      cfgRdValid <= 1'b0;
    end
    else
    begin
      cfgRdValid <= cfgStrobe && cfgIsRead;
      if (cfgStrobe && cfgIsRead)
        cfgRdData <= cfgInArea ? {chainMem[cfgOdd], chainMem[cfgEven]} : 16'h0000;
    end
  end

  // ************************************************************
  // Link timer
  // ************************************************************
  sdc_link_if link ();

  sdc_link_timer #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .link    (link.timer)
  );

  // ************************************************************
  // Sequencer state
  // ************************************************************
  sdc_state_t             state;         // Sequencer state
  sdc_state_t             next_state;    // Following state
  logic [5:0]             entryIdx;      // Chain byte being sent
  logic [DRV_W-1:0]       driverCnt;     // Driver address counter
  logic [SDC_POS_W-1:0]   bitPos;        // Bit position across the chain
  logic                   stepPending;   // Microstep waiting for a datagram
  logic                   patchActive;   // Current datagram carries the cover
  logic [SDC_POS_W-1:0]   covPos;        // Latched cover position
  logic [SDC_LEN_W-1:0]   covLen;        // Latched cover length
  logic [SDC_COVER_W-1:0] covBits;       // Latched cover sequence

  // ************************************************************
  // Bit selection
  // ************************************************************
  wire  [7:0]             entry;         // Current chain byte
  wire  [SDC_CODE_W-1:0]  sigCode;       // Primary signal code
  wire                    nextDriver;    // Advance after this bit
  wire                    genBit;        // Bit from primary signals
  wire  [SDC_POS_W-1:0]   covOff;        // Offset into cover window
  wire                    inCover;       // Bit lies in cover window
  wire  [SDC_LEN_W-1:0]   covIdx;        // Cover bit, MSB first
  wire                    txBit;         // Bit actually sent
  wire                    lastBit;       // Final bit of whole datagram
  wire                    startReq;      // Reason to send a datagram
  wire                    coverAccept;   // Cover write taken
  wire                    idle;          // Sequencer at rest

  assign entry      = chainMem[entryIdx];
  assign sigCode    = entry[SDC_CODE_LSB +: SDC_CODE_W];
  assign nextDriver = entry[SDC_NEXT_BIT];
  assign genBit     = primarySignals[{driverCnt, sigCode}];
  assign covOff     = bitPos - covPos;
  assign inCover    = patchActive && (bitPos >= covPos)
                      && (covOff < SDC_POS_W'(covLen));
  assign covIdx     = covLen - SDC_LEN_W'(1) - covOff[SDC_LEN_W-1:0];
  assign txBit      = inCover ? covBits[covIdx] : genBit;
  assign lastBit    = (nextDriver && (driverCnt == lastDriverIndex))
                      || (entryIdx == 6'(SDC_CHAIN_BYTES - 1));
  assign idle       = (state == SDC_IDLE);
  assign startReq   = stepPending || continuousUpdate || patchPendingFlag;
  assign coverAccept = coverWrite && idle && !patchPendingFlag;
  assign busy       = !idle;

  // Timer control: runs while shifting or spacing drivers
  assign link.run   = (state == SDC_SHIFT) || (state == SDC_GAP);
  assign link.quiet = (state == SDC_GAP);
  assign sckPin     = link.sck;

  // Next-state decode
  always_comb
  begin
    next_state = state;
    case (state)
      SDC_IDLE:  if (startReq) next_state = SDC_LOAD;
      SDC_LOAD:  next_state = SDC_SHIFT;
      SDC_SHIFT:
        if (link.tick)
        begin
          if (lastBit)
            next_state = SDC_IDLE;
          else if (nextDriver && selectLineMode)
            next_state = SDC_GAP;     // Deselect so the driver latches
          else
            next_state = SDC_LOAD;
        end
      SDC_GAP:   if (link.tick) next_state = SDC_LOAD;
      default:   next_state = SDC_IDLE;
    endcase
  end

  // ************************************************************
  // Sequencer registers
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state <= SDC_IDLE;
    else
      state <= next_state;
  end

  // Chain walk: index, driver counter, global bit position
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      entryIdx  <= 6'h00;
      driverCnt <= '0;
      bitPos    <= 8'h00;
    end
    else if (idle)
    begin
      entryIdx  <= 6'h00;
      driverCnt <= '0;
      bitPos    <= 8'h00;
    end
    else if (state == SDC_SHIFT && link.tick && !lastBit)
    begin
      entryIdx  <= entryIdx + 6'h01;
      bitPos    <= bitPos + 8'h01;
      if (nextDriver)
        driverCnt <= driverCnt + DRV_W'(1);
    end
  end

  // Step latch; a step arriving as the datagram starts is kept
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stepPending <= 1'b0;
    else if (stepPulse)
      stepPending <= 1'b1;
    else if (idle && startReq)
      stepPending <= 1'b0;
  end

  // Cover bookkeeping: accept, bind to one datagram, release at its end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      patchPendingFlag <= 1'b0;
      patchActive      <= 1'b0;
      covPos           <= 8'h00;
      covLen           <= 5'h00;
      covBits          <= 24'h00_0000;
    end
    else
    begin
      if (coverAccept)
      begin
        patchPendingFlag <= 1'b1;
        covPos           <= coverPosition;
        covLen           <= coverLength;
        covBits          <= coverDatagram;
      end
      if (idle && startReq)
        patchActive <= patchPendingFlag;
      else if (state == SDC_SHIFT && link.tick && lastBit && patchActive)
      begin
        patchActive      <= 1'b0;
        patchPendingFlag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Data changes in load while the serial clock is low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sdoPin <= 1'b0;
    else if (state == SDC_LOAD)
      sdoPin <= txBit;
    else if (idle)
      sdoPin <= 1'b0;
  end

  // Individual mode selects the addressed driver; common mode uses line 0
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      selectN <= '1;
    else if (state == SDC_LOAD || state == SDC_SHIFT)
    begin
      for (int d = 0; d < DRIVERS; d++)
        selectN[d] <= selectLineMode ? (DRV_W'(d) != driverCnt) : (d != 0);
    end
    else if (state == SDC_GAP && !selectLineMode)
      selectN <= selectN;
    else
      selectN <= '1;
  end

endmodule

//--- hw/sdc_pkg.sv
// Constants shared by the driver datagram chain generator and its link timer.
// Assumes a single 250 MHz controller clock; all link timing derives from it.
package sdc_pkg;

  // ************************************************************
  // Chain configuration memory
  // ************************************************************
  localparam logic [7:0] SDC_CHAIN_BASE   = 8'h80;  // First chain register address
  localparam int         SDC_CHAIN_REGS   = 32;     // Two-byte registers in the area
  localparam int         SDC_CHAIN_BYTES  = 64;     // One byte per datagram bit
  localparam int         SDC_ADDR_RW_BIT  = 0;      // Address LSB: 1 read, 0 write
  localparam int         SDC_AREA_BIT     = 7;      // Set for the chain area
  localparam int         SDC_CODE_LSB     = 0;      // Signal code field low bit
  localparam int         SDC_CODE_W       = 5;      // Signal code width
  localparam int         SDC_NEXT_BIT     = 5;      // next_driver_flag position
  localparam logic [7:0] SDC_ENTRY_RESET  = 8'h00;  // Chain byte reset value; unused, the chain array is not reset

  // ************************************************************
  // Datagram and cover parameters
  // ************************************************************
  localparam int SDC_WORD_LEN  = 19;  // Bits per driver datagram
  localparam int SDC_COVER_W   = 24;  // Cover sequence register width
  localparam int SDC_POS_W     = 8;   // Cover position and bit counter width
  localparam int SDC_LEN_W     = 5;   // Cover length width

  // ************************************************************
  // Link timing
  // ************************************************************
  localparam int SDC_CLK_PERIOD_NS = 4;   // Controller clock period
  localparam int SDC_SCK_PERIOD_NS = 32;  // Serial clock period
  localparam int SDC_SCK_HALF_CYC  =      // Cycles per serial clock half, at least one
    (SDC_SCK_PERIOD_NS / 2 + SDC_CLK_PERIOD_NS - 1) / SDC_CLK_PERIOD_NS;

  // ************************************************************
  // Sequencer states, Gray coded along idle-load-shift-gap
  // ************************************************************
  typedef enum logic [1:0]
  {
    SDC_IDLE  = 2'h0,
    SDC_LOAD  = 2'h1,
    SDC_SHIFT = 2'h3,
    SDC_GAP   = 2'h2
  } sdc_state_t;

endpackage

//--- hw/sdc_link_if.sv
// Carrier between the datagram sequencer and its serial clock timer.
// Both ends sit on ref_clk; nothing here crosses a clock domain.
`timescale 1ns/1ps
interface sdc_link_if;
  logic run;    // Timer counts while high
  logic quiet;  // Hold serial clock low while counting
  logic sck;    // Serial clock level, from a flip-flop
  logic tick;   // One-cycle pulse at the end of each serial period

  modport timer (input run, input quiet, output sck, output tick);
  modport ctrl  (output run, output quiet, input sck, input tick);
endinterface

//--- hw/sdc_link_timer.sv
// Serial clock divider for the datagram link.
// Assumes run is held for whole periods; dropping it restarts the period.
`timescale 1ns/1ps
module sdc_link_timer
  import sdc_pkg::*;
#(
  parameter int HALF_CYCLES = SDC_SCK_HALF_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic rst,
  sdc_link_if.timer link
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (HALF_CYCLES < 1 || HALF_CYCLES > 128)
  begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  localparam int CNT_W = $clog2(2 * HALF_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(2 * HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(HALF_CYCLES);

  logic [CNT_W-1:0] phase;       // Position within one serial period
  wire              atEnd;       // Last cycle of the period
  wire  [CNT_W-1:0] next_phase;  // Following position

  assign atEnd      = link.run && (phase == LAST);
  assign next_phase = (!link.run || atEnd) ? '0 : phase + CNT_W'(1);

  // Tick marks the period's last cycle itself; a registered tick would let
  // the counter wrap and raise the serial clock once more before the move
  assign link.tick  = atEnd;

  // Period counter; low half first so data settles before the rising edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase     <= '0;
      link.sck  <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      link.sck  <= link.run && !link.quiet && (next_phase >= HALF);
    end
  end

endmodule

//--- test/sdc_chain_chk.sv
// Port-level assertions for the driver datagram chain generator.
// Assumes one clock domain; bound onto every instance of the top module.
`timescale 1ns/1ps
module sdc_chain_chk
  import sdc_pkg::*;
#(
  parameter int DRV_W       = 2,
  parameter int HALF_CYCLES = SDC_SCK_HALF_CYC
)
(
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  cfgStrobe,
  input wire logic [7:0]            cfgAddr,
  input wire logic [15:0]           cfgRdData,
  input wire logic                  cfgRdValid,
  input wire logic                  stepPulse,
  input wire logic                  continuousUpdate,
  input wire logic                  coverWrite,
  input wire logic                  patchPendingFlag,
  input wire logic                  busy,
  input wire logic                  sckPin,
  input wire logic                  sdoPin,
  input wire logic [(1<<DRV_W)-1:0] selectN
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire noSel = &selectN;  // No driver addressed

  rd_answer_a: assert property (cfgStrobe && cfgAddr[0] |=> cfgRdValid)
    else $error("read strobe got no answer");
  wr_silent_a: assert property (cfgStrobe && !cfgAddr[0] |=> !cfgRdValid)
    else $error("write strobe gave a read answer");
  outside_zero_a: assert property (cfgStrobe && cfgAddr[0] && !cfgAddr[7]
    |=> cfgRdData == 16'h0000) else $error("read outside chain area not zero");
  step_start_a: assert property (stepPulse && !busy |-> ##[1:2] busy)
    else $error("step did not start a datagram");
  cont_start_a: assert property (continuousUpdate && !busy |-> ##[1:2] busy)
    else $error("continuous mode did not restart");
  idle_sel_a: assert property (!busy && !$past(busy) |-> noSel)
    else $error("select low while idle");
  one_sel_a: assert property ($onehot0(~selectN))
    else $error("more than one select low");
  sck_sel_a: assert property ($rose(sckPin) |-> !noSel)
    else $error("serial clock edge with no driver selected");
  sdo_hold_a: assert property (sckPin |-> $stable(sdoPin))
    else $error("serial data moved while clock high");
  cover_take_a: assert property (coverWrite && !busy && !patchPendingFlag
    |=> patchPendingFlag) else $error("idle cover write not taken");
  cover_drop_a: assert property (coverWrite && busy && !patchPendingFlag
    |=> !patchPendingFlag) else $error("cover write taken while busy");
  pend_clear_a: assert property ($fell(patchPendingFlag) |=> $rose(noSel))
    else $error("pending flag cleared away from datagram end");
  cover_send_a: assert property ($rose(patchPendingFlag) |-> ##[1:3] busy)
    else $error("cover did not start a datagram");

  // Main scenarios seen at least once
  step_c: cover property (stepPulse && !busy);
  pend_c: cover property ($rose(patchPendingFlag));
  cont_c: cover property (continuousUpdate && $fell(busy));
  read_c: cover property (cfgRdValid);
endmodule

bind sdc_datagram_chain sdc_chain_chk #(.DRV_W(DRV_W), .HALF_CYCLES(HALF_CYCLES)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .cfgStrobe(cfgStrobe), .cfgAddr(cfgAddr),
  .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .stepPulse(stepPulse),
  .continuousUpdate(continuousUpdate), .coverWrite(coverWrite),
  .patchPendingFlag(patchPendingFlag), .busy(busy), .sckPin(sckPin),
  .sdoPin(sdoPin), .selectN(selectN)
);

//--- test/sdc_driver_model.sv
// Behavioural bridge driver chips on the serial link, one per select line.
// Assumes data sampled on serial clock rise; frames close on select rise.
`timescale 1ns/1ps
module sdc_driver_model
(
  input wire logic       sckPin,
  input wire logic       sdoPin,
  input wire logic [3:0] selectN
);
  // ****************************************
  // Receive and word storage
  // ****************************************
  logic [63:0] rxBits [4] = '{default: '0};  // Shift register per chip
  int          rxCnt  [4] = '{default: 0};   // Bits seen in this frame
  logic [63:0] frameQ [$];                   // Closed frames, first bit high
  int          lenQ   [$];                   // Their lengths
  int          lineQ  [$];                   // Their select lines
  logic [18:0] wordReg [4][2];               // Stepping and configuration words
  logic        ready  [4] = '{default: 0};   // Configuration word seen
  logic        lowRange [4];                 // Lower current range chosen
  logic        extRef [4];                   // External current reference

  // Shift in on the rising serial clock for each selected chip
  always @(posedge sckPin)
    for (int k = 0; k < 4; k++)
      if (!selectN[k])
      begin
        rxBits[k] = {rxBits[k][62:0], sdoPin};
        rxCnt[k] = rxCnt[k] + 1;
      end

  // Frame close; empty edges at reset are skipped
  for (genvar k = 0; k < 4; k++)
  begin : g_line
    always @(posedge selectN[k])
      if (rxCnt[k] != 0)
      begin
        frameQ.push_back(rxBits[k]);
        lenQ.push_back(rxCnt[k]);
        lineQ.push_back(k);
        if (rxCnt[k] == 19)
        begin
          wordReg[k][rxBits[k][0]] = rxBits[k][18:0];
          ready[k] = ready[k] | rxBits[k][0];
          lowRange[k] = rxBits[k][0] ? lowRange[k] : !rxBits[k][18];
          extRef[k] = rxBits[k][0] ? extRef[k] : rxBits[k][17];
        end
        rxBits[k] = '0;
        rxCnt[k] = 0;
      end
  end
endmodule

//--- test/sdc_datagram_chain_tb.sv
// Self-checking bench for the datagram chain generator.
// Inputs change at the falling edge; a driver model collects the frames.
`timescale 1ns/1ps
module sdc_datagram_chain_tb
  import sdc_pkg::*;
;
  // ****************************************
  // Stimulus and model state
  // ****************************************
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         cfgStrobe = 1'b0;
  logic [7:0]   cfgAddr = 8'h00;
  logic [15:0]  cfgWrData = 16'h0000;
  logic [15:0]  cfgRdData;
  logic         cfgRdValid, patchPendingFlag, busy, sckPin, sdoPin;
  logic [127:0] primarySignals = '0;
  logic         stepPulse = 1'b0;
  logic         continuousUpdate = 1'b0;
  logic         selectLineMode = 1'b1;
  logic [1:0]   lastDriverIndex = 2'h0;
  logic         coverWrite = 1'b0;
  logic [7:0]   coverPosition = 8'h00;
  logic [4:0]   coverLength = 5'h00;
  logic [23:0]  coverDatagram = '0;
  logic [3:0]   selectN;
  int           error_cnt = 0;
  int           compares = 0;
  logic [31:0]  seed = 32'h0000_905a;  // Fixed xorshift start
  logic [7:0]   mem [64];              // Chain bytes as written
  logic [63:0]  expQ [$];              // Expected frames
  int           expLen [$];
  int           expLine [$];
  int           cnt;

  sdc_datagram_chain #(.DRV_W(2), .HALF_CYCLES(1)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .cfgStrobe(cfgStrobe), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .primarySignals(primarySignals), .stepPulse(stepPulse),
    .continuousUpdate(continuousUpdate), .selectLineMode(selectLineMode),
    .lastDriverIndex(lastDriverIndex), .coverWrite(coverWrite),
    .coverPosition(coverPosition), .coverLength(coverLength),
    .coverDatagram(coverDatagram), .patchPendingFlag(patchPendingFlag),
    .busy(busy), .sckPin(sckPin), .sdoPin(sdoPin), .selectN(selectN)
  );
  sdc_driver_model i_drv (.sckPin(sckPin), .sdoPin(sdoPin), .selectN(selectN));

  // 250 MHz clock
  initial
    forever #2 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One strobe; read answer is settled at return
  task automatic cfg(logic [7:0] a, logic [15:0] d);
    @(negedge ref_clk);
    cfgStrobe = 1'b1;
    cfgAddr = a;
    cfgWrData = d;
    @(negedge ref_clk);
    cfgStrobe = 1'b0;
  endtask

  task automatic step();
    @(negedge ref_clk);
    stepPulse = 1'b1;
    @(negedge ref_clk);
    stepPulse = 1'b0;
  endtask

  // Idle means busy low four cycles running; a step restart gap is shorter
  task automatic settle();
    int quiet;
    quiet = 0;
    for (int n = 0; n < 3000 && quiet < 4; n++)
    begin
      @(negedge ref_clk);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    check("link idle", 64'h1, 64'(quiet >= 4));
  endtask

  // Reference walk of the chain: one bit per entry, cover window patched
  task automatic build(int last, bit indiv, int cpos, int clen, logic [23:0] cd);
    logic [1:0]  drv;
    int          n;
    logic [63:0] acc;
    logic        b;
    drv = 2'h0;
    n = 0;
    acc = '0;
    for (int e = 0; e < 64; e++)
    begin
      b = primarySignals[{drv, mem[e][4:0]}];
      if (e >= cpos && e < cpos + clen)
        b = cd[clen - 1 - (e - cpos)];
      acc = {acc[62:0], b};
      n++;
      if (mem[e][5] && drv == last)
        break;
      if (mem[e][5] && indiv)
      begin
        expQ.push_back(acc);
        expLen.push_back(n);
        expLine.push_back(drv);
        acc = '0;
        n = 0;
      end
      if (mem[e][5])
        drv++;
    end
    expQ.push_back(acc);
    expLen.push_back(n);
    expLine.push_back(indiv ? drv : 0);
  endtask

  task automatic compare_frames();
    check("frame count", 64'(expQ.size()), 64'(i_drv.frameQ.size()));
    while (expQ.size() > 0 && i_drv.frameQ.size() > 0)
    begin
      check("frame bits", expQ.pop_front(), i_drv.frameQ.pop_front());
      check("frame length", 64'(expLen.pop_front()), 64'(i_drv.lenQ.pop_front()));
      check("select line", 64'(expLine.pop_front()), 64'(i_drv.lineQ.pop_front()));
    end
    expQ.delete();
    i_drv.frameQ.delete();
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("reset outputs", 64'h0f, 64'({busy, sckPin, patchPendingFlag, cfgRdValid, selectN}));
    $display("test reset done");
    // Three drivers of 19 bits; advance flag on each final entry
    for (int e = 0; e < 64; e++)
      mem[e] = {2'b00, e == 18 || e == 37 || e == 56, 5'(rnd())};
    for (int r = 0; r < 32; r++)
      cfg(8'h80 + 8'(2 * r), {mem[2 * r + 1], mem[2 * r]});
    cfg(8'h02, 16'hffff);
    for (int r = 0; r < 32; r++)
    begin
      cfg(8'h81 + 8'(2 * r), 16'h0000);
      check("chain read", 64'({mem[2 * r + 1], mem[2 * r]}), 64'(cfgRdData));
    end
    cfg(8'h03, 16'h0000);
    check("outside read", 64'h0, 64'(cfgRdData));
    $display("test config done");
    primarySignals = {rnd(), rnd(), rnd(), rnd()};
    lastDriverIndex = 2'h2;
    step();
    repeat (20) @(negedge ref_clk);
    step();
    settle();
    build(2, 1, 0, 0, '0);
    build(2, 1, 0, 0, '0);
    compare_frames();
    selectLineMode = 1'b0;
    lastDriverIndex = 2'h1;
    step();
    settle();
    build(1, 0, 0, 0, '0);
    compare_frames();
    $display("test step done");
    selectLineMode = 1'b1;
    lastDriverIndex = 2'h2;
    for (int i = 0; i < 3; i++)
    begin
      check("free before cover", 64'h0, 64'(patchPendingFlag));
      coverPosition = 8'(19 * i);
      coverLength = (i == 0) ? 5'h01 : 5'h13;
      coverDatagram = 24'(rnd()) | 24'h00_0001;
      coverWrite = 1'b1;
      @(negedge ref_clk);
      check("cover pending", 64'h1, 64'(patchPendingFlag));
      coverPosition = 8'h05;
      @(negedge ref_clk);
      coverWrite = 1'b0;
      settle();
      check("pending cleared", 64'h0, 64'(patchPendingFlag));
      build(2, 1, 19 * i, int'(coverLength), coverDatagram);
      compare_frames();
      if (i > 0) check("config word", 64'(coverDatagram[18:0]), 64'(i_drv.wordReg[i][1]));
    end
    check("config words", 64'h3, 64'({i_drv.ready[1], i_drv.ready[2]}));
    step();
    // Cover write during a stepping datagram must be ignored
    repeat (4) @(negedge ref_clk);
    coverWrite = 1'b1;
    @(negedge ref_clk);
    coverWrite = 1'b0;
    check("busy cover refused", 64'h0, 64'(patchPendingFlag));
    settle();
    build(2, 1, 0, 0, '0);
    compare_frames();
    $display("test cover done");
    lastDriverIndex = 2'h0;
    continuousUpdate = 1'b1;
    repeat (300) @(negedge ref_clk);
    continuousUpdate = 1'b0;
    settle();
    cnt = i_drv.frameQ.size();
    check("repeat sends", 64'h1, 64'(cnt >= 4));
    for (int k = 0; k < cnt; k++)
      build(0, 1, 0, 0, '0);
    compare_frames();
    repeat (200) @(negedge ref_clk);
    check("no step no send", 64'h0, 64'(i_drv.frameQ.size()));
    $display("test continuous done");
    give_verdict();
  end
endmodule
